// ===== rtl/wps_pkg.sv
package wps_pkg;

  // ----------------------------------------------------------------
  // addressing and reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] WPS_ADDR_STD = 7'h2E;
  localparam logic [6:0] WPS_ADDR_ALT = 7'h3E;
  localparam logic [6:0] WPS_ADDR_GCALL = 7'h00;
  localparam logic [6:0] WPS_WIPER_RST = 7'h3F;
  localparam logic [7:0] WPS_CMD_WIPER = 8'h00;
  localparam logic [3:0] WPS_BITS_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int WPS_CLK_HZ = 20000000;
  localparam int WPS_FAST_BPS = 400000;
  localparam int WPS_STD_BPS = 100000;
  // sampled clock period at fast rate, in system cycles
  localparam int WPS_FAST_CYC = WPS_CLK_HZ / WPS_FAST_BPS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic scl;
    logic sda;
  } wps_line_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
  } wps_event_t;

  typedef struct packed {
    logic strobe;
    logic [6:0] data;
  } wps_wr_t;

  typedef enum logic [2:0] {
    WPS_IDLE = 3'b000,
    WPS_RECV = 3'b001,
    WPS_ACK = 3'b010,
    WPS_SEND = 3'b011,
    WPS_MACK = 3'b100,
    WPS_IGNORE = 3'b101
  } wps_state_t;

  typedef enum logic [1:0] {
    WPS_PH_ADDR = 2'b00,
    WPS_PH_CMD = 2'b01,
    WPS_PH_DATA = 2'b10
  } wps_phase_t;

endpackage : wps_pkg

// ===== rtl/wps_line_sync.sv
module wps_line_sync
  import wps_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw pins
  input wire logic scl_in,
  input wire logic sda_in,
  // sampled lines and events
  output wps_pkg::wps_line_t line,
  output wps_pkg::wps_event_t ev
);

  logic [1:0] meta;
  wps_line_t sync;
  wps_line_t prev;

  // ----------------------------------------------------------------
  // two-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 2'b11;
      sync <= '1;
    end else begin
      meta <= {scl_in, sda_in};
      sync <= meta;
    end
  end

  // ----------------------------------------------------------------
  // history for edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= '1;
    end else begin
      prev <= sync;
    end
  end

  assign line = sync;
  // conditions only while the clock stays high across both samples
  assign ev.start = prev.scl && sync.scl && prev.sda && !sync.sda;
  assign ev.stop = prev.scl && sync.scl && !prev.sda && sync.sda;
  assign ev.scl_rise = !prev.scl && sync.scl;
  assign ev.scl_fall = prev.scl && !sync.scl;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  start_excl_a : assert property (@(posedge clk) disable iff (!rst_n)
    !(ev.start && ev.stop)) else $error("start and stop together");
  start_sda_a : assert property (@(posedge clk) disable iff (!rst_n)
    ev.start |-> $past(sync.sda) && !sync.sda && sync.scl)
    else $error("start not a falling data line");
  stop_sda_a : assert property (@(posedge clk) disable iff (!rst_n)
    ev.stop |-> !$past(sync.sda) && sync.sda && sync.scl)
    else $error("stop not a rising data line");

endmodule : wps_line_sync

// ===== rtl/wps_slave.sv
module wps_slave
  import wps_pkg::*;
#(
  parameter bit ALT_ADDR = 1'b0
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial clock pin, input only
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  // serial data pin, open drain
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // wiper register
  output logic [6:0] wiper,
  output wps_pkg::wps_wr_t wr,
  output logic busy
);
  import wps_pkg::*;

  localparam logic [6:0] OWN_ADDR = ALT_ADDR ? WPS_ADDR_ALT : WPS_ADDR_STD;

  wps_line_t line;
  wps_event_t ev;
  wps_state_t state;
  wps_phase_t phase;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] cmd;
  logic [7:0] tx;
  logic rd_dir;
  logic drive_low;
  logic mack;
  logic last_ack_data;
  logic restart_win;

  // ----------------------------------------------------------------
  // line sampling
  // ----------------------------------------------------------------
  wps_line_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .line(line),
    .ev(ev)
  );

  // clock pin is never driven: no stretching, master owns it
  assign scl_out = 1'b1;
  assign scl_oe_n = 1'b1;
  assign sda_out = 1'b0;
  assign sda_oe_n = !drive_low;
  assign busy = (state != WPS_IDLE) && (state != WPS_IGNORE);

  // ----------------------------------------------------------------
  // bit counter and receive shift
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 4'h0;
      shift <= 8'h00;
    end else if (ev.start || ev.stop) begin
      bit_cnt <= 4'h0;
    end else if (state == WPS_RECV && ev.scl_rise) begin
      // data is sampled only on the rising edge, stable while high
      shift <= {shift[6:0], line.sda};
      bit_cnt <= bit_cnt + 4'h1;
    end else if (state == WPS_SEND && ev.scl_fall) begin
      bit_cnt <= bit_cnt + 4'h1;
    end else if (ev.scl_fall && (state == WPS_ACK || state == WPS_MACK)) begin
      bit_cnt <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // transfer state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= WPS_IDLE;
      phase <= WPS_PH_ADDR;
      rd_dir <= 1'b0;
    end else if (ev.stop) begin
      state <= WPS_IDLE;
    end else if (ev.start) begin
      // start and repeated start both restart reception
      state <= WPS_RECV;
      phase <= WPS_PH_ADDR;
    end else begin
      unique case (state)
        WPS_IDLE, WPS_IGNORE: begin
          state <= state;
        end
        WPS_RECV: begin
          if (ev.scl_fall && bit_cnt == WPS_BITS_BYTE) begin
            if (phase == WPS_PH_ADDR) begin
              if (shift[7:1] == OWN_ADDR) begin
                state <= WPS_ACK;
                rd_dir <= shift[0];
              end else begin
                // mismatch and general call both fall off the bus
                state <= WPS_IGNORE;
              end
            end else begin
              state <= WPS_ACK;
            end
          end
        end
        WPS_ACK: begin
          if (ev.scl_fall) begin
            if (phase == WPS_PH_ADDR && rd_dir) begin
              state <= WPS_SEND;
              phase <= WPS_PH_DATA;
            end else begin
              state <= WPS_RECV;
              phase <= (phase == WPS_PH_ADDR) ? WPS_PH_CMD : WPS_PH_DATA;
            end
          end
        end
        WPS_SEND: begin
          if (ev.scl_fall && bit_cnt == WPS_BITS_BYTE - 4'h1) begin
            state <= WPS_MACK;
          end
        end
        WPS_MACK: begin
          if (ev.scl_fall) begin
            state <= mack ? WPS_SEND : WPS_IGNORE;
          end
        end
        default: begin
          state <= WPS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // master acknowledge capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mack <= 1'b0;
    end else if (state == WPS_MACK && ev.scl_rise) begin
      mack <= !line.sda;
    end
  end

  // ----------------------------------------------------------------
  // repeated start collision window
  // ----------------------------------------------------------------
  // opens once the clock rises with data high after an acknowledge;
  // a start then closes it, a clock fall or low data means collision
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_win <= 1'b0;
    end else if (ev.start || ev.stop) begin
      restart_win <= 1'b0;
    end else if (state == WPS_RECV && bit_cnt == 4'h0 && phase != WPS_PH_ADDR
                 && ev.scl_rise) begin
      restart_win <= line.sda;
    end else if (ev.scl_fall) begin
      restart_win <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // command register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= WPS_CMD_WIPER;
    end else if (state == WPS_ACK && phase == WPS_PH_CMD && ev.scl_fall) begin
      cmd <= shift;
    end
  end

  // ----------------------------------------------------------------
  // wiper register and write strobe
  // ----------------------------------------------------------------
  // commit happens at the acknowledge of a complete data byte; a
  // cut-short byte never reaches that state, so it writes nothing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wiper <= WPS_WIPER_RST;
      wr <= '0;
    end else begin
      wr.strobe <= 1'b0;
      if (state == WPS_RECV && phase == WPS_PH_DATA && !ev.start && !ev.stop
          && ev.scl_fall && bit_cnt == WPS_BITS_BYTE) begin
        // top bit dropped: the register is seven bits wide
        wiper <= shift[6:0];
        wr.strobe <= 1'b1;
        wr.data <= shift[6:0];
      end
    end
  end

  assign last_ack_data = (state == WPS_RECV) && (phase == WPS_PH_DATA);

  // ----------------------------------------------------------------
  // transmit byte
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx <= 8'h00;
    end else if ((state == WPS_ACK || state == WPS_MACK) && ev.scl_fall) begin
      // other command codes return zero, not the wiper
      tx <= (cmd == WPS_CMD_WIPER) ? {1'b0, wiper} : 8'h00;
    end else if (state == WPS_SEND && ev.scl_fall) begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // data line driver
  // ----------------------------------------------------------------
  // set on clock falls only so the line is steady while high; start, stop and a collision release it at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_low <= 1'b0;
    end else if (ev.stop || ev.start) begin
      drive_low <= 1'b0;
    end else if (restart_win && (ev.scl_fall || !line.sda)) begin
      drive_low <= 1'b0;
    end else if (ev.scl_fall) begin
      unique case (state)
        WPS_RECV: drive_low <= bit_cnt == WPS_BITS_BYTE
          && !(phase == WPS_PH_ADDR && shift[7:1] != OWN_ADDR);
        // first bit out is always the zero top bit, whatever the command
        WPS_ACK: drive_low <= phase == WPS_PH_ADDR && rd_dir;
        WPS_SEND: drive_low <= bit_cnt != WPS_BITS_BYTE - 4'h1 && !tx[6];
        WPS_MACK: drive_low <= mack;
        default: drive_low <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // collision flag, feeding coverage only
  // ----------------------------------------------------------------
  logic collide;
  assign collide = restart_win && (ev.scl_fall || !line.sda) && !ev.start;

  logic collide_seen;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      collide_seen <= 1'b0;
    end else begin
      collide_seen <= collide && !last_ack_data;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  scl_free_a : assert property (@(posedge clk) disable iff (!rst_n)
    scl_oe_n) else $error("clock line driven");
  stop_idle_a : assert property (@(posedge clk) disable iff (!rst_n)
    ev.stop |=> state == WPS_IDLE && sda_oe_n) else $error("stop not idle");
  start_recv_a : assert property (@(posedge clk) disable iff (!rst_n)
    ev.start && !ev.stop |=> state == WPS_RECV && phase == WPS_PH_ADDR)
    else $error("start not restarting");
  sda_steady_a : assert property (@(posedge clk) disable iff (!rst_n)
    line.scl && $past(line.scl) && !$past(ev.start) && !$past(ev.stop)
    && !$past(restart_win) |-> $stable(sda_oe_n))
    else $error("data changed while clock high");
  addr_nack_a : assert property (@(posedge clk) disable iff (!rst_n)
    state == WPS_RECV && phase == WPS_PH_ADDR && bit_cnt == WPS_BITS_BYTE
    && shift[7:1] != OWN_ADDR && ev.scl_fall && !ev.start && !ev.stop
    |=> sda_oe_n && state == WPS_IGNORE) else $error("bad address acked");
  addr_ack_a : assert property (@(posedge clk) disable iff (!rst_n)
    state == WPS_RECV && phase == WPS_PH_ADDR && bit_cnt == WPS_BITS_BYTE
    && shift[7:1] == OWN_ADDR && ev.scl_fall && !ev.start && !ev.stop
    |=> !sda_oe_n && state == WPS_ACK) else $error("address not acked");
  wiper_hold_a : assert property (@(posedge clk) disable iff (!rst_n)
    !$past(wr.strobe) && !wr.strobe |-> $stable(wiper))
    else $error("wiper changed without strobe");
  mack_end_a : assert property (@(posedge clk) disable iff (!rst_n)
    state == WPS_MACK && !mack && ev.scl_fall && !ev.start && !ev.stop
    |=> sda_oe_n && state == WPS_IGNORE) else $error("kept sending");
  wr_msb_a : assert property (@(posedge clk) disable iff (!rst_n)
    wr.strobe |-> wiper == wr.data && $past(shift[6:0]) == wr.data)
    else $error("write data mismatch");

  write_c : cover property (@(posedge clk) disable iff (!rst_n) wr.strobe);
  read_c : cover property (@(posedge clk) disable iff (!rst_n) state == WPS_SEND);
  nack_c : cover property (@(posedge clk) disable iff (!rst_n)
    state == WPS_MACK && ev.scl_fall && !mack);
  collide_c : cover property (@(posedge clk) disable iff (!rst_n) collide_seen);

endmodule : wps_slave

// ===== tb/wps_master_model.sv
module wps_master_model (
  // clock
  input wire logic clk,
  // bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  timeunit 1ns;
  timeprecision 1ns;

  // released lines rest high on the pull-ups, clock stands still between frames
  initial begin
    scl = 1'h1;
    sda_m = 1'h1;
  end

  // ----------------------------------------------------------------
  // bit timing: quarter period of 100 ns, 400 ns a bit
  // ----------------------------------------------------------------
  task automatic q();
    repeat (2) @(negedge clk);
  endtask : q

  task automatic start();
    sda_m = 1'h1;
    q();
    scl = 1'h1;
    q();
    sda_m = 1'h0;
    q();
    scl = 1'h0;
    q();
  endtask : start

  task automatic stop();
    sda_m = 1'h0;
    q();
    scl = 1'h1;
    q();
    sda_m = 1'h1;
    q();
    // let the synchronised stop reach the device before anyone looks
    q();
  endtask : stop

  // data set mid-low, sampled mid-high so slow device updates settle
  task automatic xfer(input logic b, output logic r);
    sda_m = b;
    q();
    scl = 1'h1;
    q();
    r = sda;
    q();
    scl = 1'h0;
    q();
  endtask : xfer

  task automatic wr_byte(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], r);
    end
    xfer(1'h1, nak);
  endtask : wr_byte

  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'h1, r);
      d[i] = r;
    end
    xfer(last, r);
  endtask : rd_byte

  // second start keeps a stray acknowledge from committing a write
  task automatic recover();
    logic r;
    start();
    repeat (9) xfer(1'h1, r);
    start();
    stop();
  endtask : recover
endmodule : wps_master_model

// ===== tb/test_i2c_wiper_register_slave.sv
module test_i2c_wiper_register_slave;
  timeunit 1ns;
  timeprecision 1ns;
  import wps_pkg::*;

  logic clk;
  logic rst_n;
  logic scl;
  logic sda_m;
  logic sda;
  logic sda_out;
  logic sda_oe_n;
  logic alt_out;
  logic alt_oe_n;
  logic scl_oe_n;
  logic busy;
  logic [6:0] wiper;
  logic [6:0] alt_wiper;
  logic [6:0] exp_w;
  wps_wr_t wr;
  int err_total = 0;
  int check_count = 0;
  int n_wr = 0;
  int exp_wr = 0;
  int seed;
  logic a;
  logic [7:0] d;
  logic [7:0] c;

  // open-drain wired-and with pull-up
  assign sda = sda_m & (sda_oe_n | sda_out) & (alt_oe_n | alt_out);

  wps_slave #(.ALT_ADDR(1'h0)) dut_u (.clk(clk), .rst_n(rst_n), .scl_in(scl), .scl_out(),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .wiper(wiper), .wr(wr), .busy(busy));
  wps_slave #(.ALT_ADDR(1'h1)) alt_u (.clk(clk), .rst_n(rst_n), .scl_in(scl), .scl_out(),
    .scl_oe_n(), .sda_in(sda), .sda_out(alt_out), .sda_oe_n(alt_oe_n),
    .wiper(alt_wiper), .wr(), .busy());
  wps_master_model m_u (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic results();
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  function automatic logic [7:0] exp_read(input logic [7:0] cmd, input logic [6:0] w);
    return (cmd == WPS_CMD_WIPER) ? {1'h0, w} : 8'h00;
  endfunction : exp_read

  always @(posedge clk) begin
    if (wr.strobe === 1'h1) begin
      n_wr++;
      check(8'(wr.data), 8'(exp_w), "strobe data");
    end
  end

  // control byte then command; expected acknowledge given
  task automatic open_w(input logic [6:0] ad, input logic [7:0] cmd, input logic nak);
    m_u.start();
    m_u.wr_byte({ad, 1'h0}, a);
    check(8'(a), 8'(nak), "address ack");
    m_u.wr_byte(cmd, a);
  endtask : open_w

  task automatic read_back(input logic [7:0] cmd);
    m_u.start();
    m_u.wr_byte({WPS_ADDR_STD, 1'h1}, a);
    check(8'(a), 8'h00, "read ack");
    m_u.rd_byte(1'h1, d);
    check(d, exp_read(cmd, exp_w), "read data");
    repeat (4) @(negedge clk);
    check(8'(sda_oe_n), 8'h01, "release after nack");
    m_u.stop();
    check(8'(busy), 8'h00, "idle after stop");
  endtask : read_back

  initial begin
    seed = 32'hC5025F0C;
    rst_n = 1'h0;
    repeat (12) @(posedge clk);
    @(negedge clk) rst_n = 1'h1;
    repeat (4) @(negedge clk);
    exp_w = WPS_WIPER_RST;
    check(8'(wiper), 8'h3F, "reset wiper");
    check(8'(alt_wiper), 8'h3F, "reset alt wiper");
    // random single and back-to-back writes, the last write of each pass read back
    for (int i = 0; i < 6; i++) begin
      open_w(WPS_ADDR_STD, WPS_CMD_WIPER, 1'h0);
      repeat (1 + (i % 2)) begin
        d = $random(seed);
        exp_w = d[6:0];
        exp_wr++;
        m_u.wr_byte(d, a);
        check(8'(a), 8'h00, "data ack");
        check(8'(wiper), 8'(exp_w), "wiper written");
      end
      read_back(WPS_CMD_WIPER);
    end
    // non-zero command codes hide the wiper
    for (int i = 0; i < 4; i++) begin
      c = (i == 0) ? 8'hFF : 8'($random(seed));
      if (c == 8'h00) c = 8'h01;
      open_w(WPS_ADDR_STD, c, 1'h0);
      read_back(c);
    end
    // general call and foreign addresses refused, payload ignored
    for (int i = 0; i < 4; i++) begin
      c = (i == 0) ? 8'(WPS_ADDR_GCALL) : 8'($random(seed) & 32'h7F);
      if (c[6:0] == WPS_ADDR_STD || c[6:0] == WPS_ADDR_ALT) c = 8'h01;
      open_w(c[6:0], WPS_CMD_WIPER, 1'h1);
      m_u.wr_byte(8'h15, a);
      check(8'(a), 8'h01, "ignored data");
      m_u.stop();
      check(8'(wiper), 8'(exp_w), "wiper kept");
    end
    // alternate build address
    open_w(WPS_ADDR_ALT, WPS_CMD_WIPER, 1'h0);
    m_u.wr_byte(8'hA9, a);
    m_u.stop();
    check(8'(alt_wiper), 8'h29, "alt wiper");
    check(8'(wiper), 8'(exp_w), "std wiper kept");
    // stop in mid byte writes nothing
    open_w(WPS_ADDR_STD, WPS_CMD_WIPER, 1'h0);
    repeat (4) m_u.xfer(1'h0, a);
    m_u.stop();
    check(8'(wiper), 8'(exp_w), "abort by stop");
    // start in mid byte restarts reception
    open_w(WPS_ADDR_STD, WPS_CMD_WIPER, 1'h0);
    repeat (5) m_u.xfer(1'h1, a);
    check(8'(wiper), 8'(exp_w), "abort by start");
    open_w(WPS_ADDR_STD, WPS_CMD_WIPER, 1'h0);
    exp_w = 7'h55;
    exp_wr++;
    m_u.wr_byte(8'hD5, a);
    m_u.stop();
    check(8'(wiper), 8'h55, "write after restart");
    // recovery while the device drives read data
    open_w(WPS_ADDR_STD, WPS_CMD_WIPER, 1'h0);
    m_u.start();
    m_u.wr_byte({WPS_ADDR_STD, 1'h1}, a);
    repeat (3) m_u.xfer(1'h1, a);
    m_u.recover();
    check(8'(wiper), 8'h55, "recovery keeps wiper");
    check(8'(busy), 8'h00, "recovery idle");
    open_w(WPS_ADDR_STD, WPS_CMD_WIPER, 1'h0);
    read_back(WPS_CMD_WIPER);
    // two-byte read: master acknowledges the first byte
    open_w(WPS_ADDR_STD, WPS_CMD_WIPER, 1'h0);
    m_u.start();
    m_u.wr_byte({WPS_ADDR_STD, 1'h1}, a);
    m_u.rd_byte(1'h0, d);
    check(d, exp_read(WPS_CMD_WIPER, exp_w), "first read byte");
    m_u.rd_byte(1'h1, d);
    check(d, exp_read(WPS_CMD_WIPER, exp_w), "second read byte");
    m_u.stop();
    check(8'(busy), 8'h00, "idle after long read");
    check(8'(n_wr), 8'(exp_wr), "commit count");
    check(8'(scl_oe_n), 8'h01, "clock never held");
    results();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    results();
  end
endmodule : test_i2c_wiper_register_slave
